// File: core/fsc_control_regs.v
// Fiber and SGMII control register bank with pin function multiplexer
//
// Notes on behaviour
// - Low pin select codes 0-7 route pin, except reserved 1 and 4 (drive low)
// - Codes 8-D route extra sources, E and F drive 0 and 1; reset A
// - Delimiter enable forces receive delimiter onto pin
// - Link-loss bit 0: zero enables, resets one
// - Fiber space at C00 shared by modes
// - Bit 15 resets fiber logic, self-clears
// - Bit 14 enables MAC-side loopback
// - Speed code from bits 13 and 6
// - Bit 12 enables autoneg, strap preset
// - Bit 11 powers down, holds logic reset
// - Bit 10 isolates MAC, except SGMII-to-RGMII bridge
// - Bit 9 restarts autoneg, except SGMII-to-RGMII bridge, self-clears
// - Bit 8 forces duplex in MII-FX only
// - Bit 7 asserts collision on transmit enable
// - Speed bits 13 and 6 rule SGMII without autoneg
`timescale 1ns/1ps
`include "fsc_defs.vh"

module fsc_control_regs (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst,
	// AXI4-Lite write address and data
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [`FSC_ADDR_W-1:0] i_s_axi_awaddr,
	input wire [2:0] i_s_axi_awprot,
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	// AXI4-Lite write response
	output wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	output wire [1:0] o_s_axi_bresp,
	// AXI4-Lite read
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	input wire [`FSC_ADDR_W-1:0] i_s_axi_araddr,
	input wire [2:0] i_s_axi_arprot,
	output wire o_s_axi_rvalid,
	input wire i_s_axi_rready,
	output wire [31:0] o_s_axi_rdata,
	output wire [1:0] o_s_axi_rresp,
	// Strap pins
	input wire [1:0] i_strap_speed,
	input wire i_strap_aneg,
	// Operating mode from the mode decode logic
	input wire i_mode_sgmii_to_rgmii_bridge,
	input wire i_mode_mii_fx,
	// Pin multiplexer sources
	input wire i_clk_out_src,
	input wire i_int_src,
	input wire i_link_status,
	input wire i_tx_sfd_pulse,
	input wire i_receive_delimiter_pulse,
	input wire i_wol_ind,
	input wire i_energy_detect,
	input wire i_pseudo_random_pattern_error,
	input wire i_led_two,
	input wire i_led_general_output,
	input wire i_mii_crs,
	input wire i_mii_col,
	input wire i_sfd_enable,
	// Transmit enable for the collision test
	input wire i_tx_en,
	// Multiplexed pin
	output wire o_mux_pin,
	// Fiber path controls
	output wire o_fiber_reset,
	output wire o_mac_loopback,
	output wire [1:0] o_speed_code,
	output wire o_sgmii_forced_speed_valid,
	output wire o_autoneg_enable,
	output wire o_autoneg_restart,
	output wire o_sgmii_power_down,
	output wire o_mac_isolate,
	output wire o_forced_duplex_valid,
	output wire o_forced_duplex_full,
	output wire o_collision_test,
	output wire o_link_loss_enable,
	// Interrupt
	output wire o_irq
);

	// ==========================================================
	// Registers
	// ==========================================================
	reg aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
	reg [`FSC_ADDR_W-1:0] aw_addr_reg;
	reg [1:0] w_strb_reg, bresp_reg, rresp_reg;
	reg [15:0] w_data_reg, rdata_reg, pin_mux_reg, link_loss_reg, ctrl_reg, ctrl_next;
	reg [`FSC_IRQ_W-1:0] irq_status_reg, irq_status_next, irq_mask_reg;
	reg [`FSC_RST_CNT_W-1:0] rst_cnt_reg;
	reg an_restart_reg, col_test_reg, col_prev_reg, mux_pin_reg, mux_pin_next;
	reg [2:0] strap_s1_reg, strap_s2_reg, strap_s3_reg, strap_cnt_reg;
	reg strap_done_reg;

	wire do_write, do_read, wr_ctrl, rd_status, rst_done, strap_load, col_now;
	wire [`FSC_IRQ_W-1:0] events;

	// Byte-lane merge for the 16-bit registers in the low half word
	function [15:0] fsc_merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [1:0] strb;
		begin
			fsc_merge[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
			fsc_merge[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
		end
	endfunction

	// ==========================================================
	// AXI4-Lite slave
	// ==========================================================
	// Address and data are held independently; the write runs once both are in
	assign o_s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign o_s_axi_wready = ~w_hold_reg & ~bvalid_reg;
	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp = bresp_reg;
	assign o_s_axi_arready = ~rvalid_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata = {16'h0000, rdata_reg};
	assign o_s_axi_rresp = rresp_reg;
	assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	assign do_read = i_s_axi_arvalid & ~rvalid_reg;
	assign wr_ctrl = do_write & (aw_addr_reg == `FSC_OFF_CTRL);
	assign rd_status = do_read & (i_s_axi_araddr == `FSC_OFF_IRQ_STATUS);

	// Write channel capture and response
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= {`FSC_ADDR_W{1'b0}};
			w_hold_reg <= 1'b0;
			w_data_reg <= 16'h0000;
			w_strb_reg <= 2'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `FSC_RESP_OKAY;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= i_s_axi_wdata[15:0];
				w_strb_reg <= i_s_axi_wstrb[1:0];
			end
			if (do_write) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				case (aw_addr_reg)
					`FSC_OFF_PIN_MUX, `FSC_OFF_LINK_LOSS, `FSC_OFF_CTRL,
					`FSC_OFF_IRQ_STATUS, `FSC_OFF_IRQ_MASK: bresp_reg <= `FSC_RESP_OKAY;
					default: bresp_reg <= `FSC_RESP_SLVERR;
				endcase
			end else if (bvalid_reg && i_s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read channel: data registered one cycle after the address is taken
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 16'h0000;
			rresp_reg <= `FSC_RESP_OKAY;
		end else if (do_read) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= `FSC_RESP_OKAY;
			case (i_s_axi_araddr)
				`FSC_OFF_PIN_MUX: rdata_reg <= pin_mux_reg;
				`FSC_OFF_LINK_LOSS: rdata_reg <= link_loss_reg;
				`FSC_OFF_CTRL: rdata_reg <= ctrl_reg;
				`FSC_OFF_IRQ_STATUS: rdata_reg <= {13'h0000, irq_status_reg};
				`FSC_OFF_IRQ_MASK: rdata_reg <= {13'h0000, irq_mask_reg};
				default: begin
					rdata_reg <= 16'h0000;
					rresp_reg <= `FSC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && i_s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Strap capture
	// ==========================================================
	// Three-stage sync; loaded once when the last two stages agree after settling
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			strap_s1_reg <= 3'h0;
			strap_s2_reg <= 3'h0;
			strap_s3_reg <= 3'h0;
			strap_cnt_reg <= 3'h0;
			strap_done_reg <= 1'b0;
		end else begin
			strap_s1_reg <= {i_strap_aneg, i_strap_speed};
			strap_s2_reg <= strap_s1_reg;
			strap_s3_reg <= strap_s2_reg;
			if (strap_cnt_reg != `FSC_STRAP_SETTLE)
				strap_cnt_reg <= strap_cnt_reg + 3'h1;
			if (strap_load)
				strap_done_reg <= 1'b1;
		end
	end

	assign strap_load = ~strap_done_reg & (strap_cnt_reg == `FSC_STRAP_SETTLE) & (strap_s2_reg == strap_s3_reg);

	// ==========================================================
	// Configuration registers
	// ==========================================================
	// Pin mux, link-loss and mask are plain read/write words
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_mux_reg <= `FSC_RST_PIN_MUX;
			link_loss_reg <= `FSC_RST_LINK_LOSS;
			irq_mask_reg <= `FSC_RST_IRQ_MASK;
		end else if (do_write) begin
			if (aw_addr_reg == `FSC_OFF_PIN_MUX)
				pin_mux_reg <= fsc_merge(pin_mux_reg, w_data_reg, w_strb_reg);
			if (aw_addr_reg == `FSC_OFF_LINK_LOSS)
				link_loss_reg <= fsc_merge(link_loss_reg, w_data_reg, w_strb_reg);
			if ((aw_addr_reg == `FSC_OFF_IRQ_MASK) && w_strb_reg[0])
				irq_mask_reg <= w_data_reg[`FSC_IRQ_W-1:0];
		end
	end

	// Control word; self-clearing bits are owned by the reset counter and restart pulse
	always @* begin
		ctrl_next = ctrl_reg;
		if (strap_load) begin
			ctrl_next[`FSC_B_SPEED_LO] = strap_s3_reg[0];
			ctrl_next[`FSC_B_SPEED_HI] = strap_s3_reg[1];
			ctrl_next[`FSC_B_ANEG_EN] = strap_s3_reg[2];
		end
		if (wr_ctrl) begin
			ctrl_next = fsc_merge(ctrl_reg, w_data_reg, w_strb_reg);
			// A written 0 cannot cut a running reset short
			ctrl_next[`FSC_B_SOFT_RST] = ctrl_reg[`FSC_B_SOFT_RST] |
				(w_strb_reg[1] & w_data_reg[`FSC_B_SOFT_RST]);
			ctrl_next[`FSC_B_ANEG_RESTART] = w_strb_reg[1] & w_data_reg[`FSC_B_ANEG_RESTART];
		end else begin
			ctrl_next[`FSC_B_ANEG_RESTART] = 1'b0;
		end
		if (rst_done)
			ctrl_next[`FSC_B_SOFT_RST] = 1'b0;
	end

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			ctrl_reg <= `FSC_RST_CTRL;
		else
			ctrl_reg <= ctrl_next;
	end

	// ==========================================================
	// Fiber soft reset and autoneg restart
	// ==========================================================
	// Counter bounds the reset so the bit always clears on its own
	assign rst_done = ctrl_reg[`FSC_B_SOFT_RST] & (rst_cnt_reg == `FSC_FIBER_RST_CYC - 1);

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rst_cnt_reg <= {`FSC_RST_CNT_W{1'b0}};
			an_restart_reg <= 1'b0;
		end else begin
			if (!ctrl_reg[`FSC_B_SOFT_RST] || rst_done)
				rst_cnt_reg <= {`FSC_RST_CNT_W{1'b0}};
			else
				rst_cnt_reg <= rst_cnt_reg + {{(`FSC_RST_CNT_W-1){1'b0}}, 1'b1};
			an_restart_reg <= ctrl_reg[`FSC_B_ANEG_RESTART] & ~i_mode_sgmii_to_rgmii_bridge;
		end
	end

	// ==========================================================
	// Collision test and pin multiplexer
	// ==========================================================
	// Collision follows transmit enable one cycle later, registered for clean output
	assign col_now = ctrl_reg[`FSC_B_COL_TEST] & i_tx_en;

	always @* begin
		case (pin_mux_reg[`FSC_SEL_HI:`FSC_SEL_LO])
			`FSC_SEL_CLK_OUT: mux_pin_next = i_clk_out_src;
			`FSC_SEL_INT: mux_pin_next = i_int_src;
			`FSC_SEL_LINK: mux_pin_next = i_link_status;
			`FSC_SEL_TX_SFD: mux_pin_next = i_tx_sfd_pulse;
			`FSC_SEL_RX_DELIM: mux_pin_next = i_receive_delimiter_pulse;
			`FSC_SEL_WOL: mux_pin_next = i_wol_ind;
			`FSC_SEL_ENERGY: mux_pin_next = i_energy_detect;
			`FSC_SEL_PSEUDO_RANDOM_PATTERN: mux_pin_next = i_pseudo_random_pattern_error;
			`FSC_SEL_LED2: mux_pin_next = i_led_two;
			`FSC_SEL_LED_GPO: mux_pin_next = i_led_general_output;
			`FSC_SEL_CRS: mux_pin_next = i_mii_crs;
			`FSC_SEL_COL: mux_pin_next = i_mii_col;
			`FSC_SEL_ZERO: mux_pin_next = 1'b0;
			`FSC_SEL_ONE: mux_pin_next = 1'b1;
			default: mux_pin_next = 1'b0; // Reserved codes drive low
		endcase
		if (i_sfd_enable)
			mux_pin_next = i_receive_delimiter_pulse;
	end

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			mux_pin_reg <= 1'b0;
			col_test_reg <= 1'b0;
			col_prev_reg <= 1'b0;
		end else begin
			mux_pin_reg <= mux_pin_next;
			col_test_reg <= col_now;
			col_prev_reg <= col_test_reg;
		end
	end

	// ==========================================================
	// Interrupts
	// ==========================================================
	// Read clears; a new event in the same cycle wins over the clear
	assign events = {col_test_reg & ~col_prev_reg, an_restart_reg, rst_done};

	always @* begin
		irq_status_next = irq_status_reg;
		if (rd_status)
			irq_status_next = {`FSC_IRQ_W{1'b0}};
		irq_status_next = irq_status_next | events;
	end

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			irq_status_reg <= {`FSC_IRQ_W{1'b0}};
		else
			irq_status_reg <= irq_status_next;
	end

	assign o_irq = |(irq_status_reg & irq_mask_reg);

	// ==========================================================
	// Outputs
	// ==========================================================
	assign o_mux_pin = mux_pin_reg;
	assign o_fiber_reset = ctrl_reg[`FSC_B_SOFT_RST] | ctrl_reg[`FSC_B_PWRDN];
	assign o_mac_loopback = ctrl_reg[`FSC_B_LOOPBACK];
	assign o_speed_code = {ctrl_reg[`FSC_B_SPEED_HI], ctrl_reg[`FSC_B_SPEED_LO]};
	assign o_sgmii_forced_speed_valid = ~ctrl_reg[`FSC_B_ANEG_EN];
	assign o_autoneg_enable = ctrl_reg[`FSC_B_ANEG_EN];
	assign o_autoneg_restart = an_restart_reg;
	assign o_sgmii_power_down = ctrl_reg[`FSC_B_PWRDN];
	assign o_mac_isolate = ctrl_reg[`FSC_B_ISOLATE] & ~i_mode_sgmii_to_rgmii_bridge;
	assign o_forced_duplex_valid = i_mode_mii_fx;
	assign o_forced_duplex_full = ctrl_reg[`FSC_B_DUPLEX];
	assign o_collision_test = col_test_reg;
	assign o_link_loss_enable = ~link_loss_reg[`FSC_B_LL_DISABLE];

endmodule

// File: core/fsc_defs.vh
// Constants for the fiber and SGMII control register block
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH

// Byte addresses on the register bus
`define FSC_ADDR_W 12
`define FSC_OFF_PIN_MUX 12'h1E0
`define FSC_OFF_LINK_LOSS 12'h1EC
`define FSC_OFF_CTRL 12'hC00
`define FSC_OFF_IRQ_STATUS 12'hD00
`define FSC_OFF_IRQ_MASK 12'hD04

// Reset values
`define FSC_RST_PIN_MUX 16'h417A
`define FSC_RST_LINK_LOSS 16'h1FFD
`define FSC_RST_CTRL 16'h1140
`define FSC_RST_IRQ_MASK 3'h0

// Control register bit positions
`define FSC_B_SOFT_RST 15
`define FSC_B_LOOPBACK 14
`define FSC_B_SPEED_LO 13
`define FSC_B_ANEG_EN 12
`define FSC_B_PWRDN 11
`define FSC_B_ISOLATE 10
`define FSC_B_ANEG_RESTART 9
`define FSC_B_DUPLEX 8
`define FSC_B_COL_TEST 7
`define FSC_B_SPEED_HI 6
`define FSC_B_LL_DISABLE 0

// Pin select field and its codes
`define FSC_SEL_HI 3
`define FSC_SEL_LO 0
`define FSC_SEL_CLK_OUT 4'h0
`define FSC_SEL_INT 4'h2
`define FSC_SEL_LINK 4'h3
`define FSC_SEL_TX_SFD 4'h5
`define FSC_SEL_RX_DELIM 4'h6
`define FSC_SEL_WOL 4'h7
`define FSC_SEL_ENERGY 4'h8
`define FSC_SEL_PSEUDO_RANDOM_PATTERN 4'h9
`define FSC_SEL_LED2 4'hA
`define FSC_SEL_LED_GPO 4'hB
`define FSC_SEL_CRS 4'hC
`define FSC_SEL_COL 4'hD
`define FSC_SEL_ZERO 4'hE
`define FSC_SEL_ONE 4'hF

// Interrupt status bits
`define FSC_IRQ_W 3
`define FSC_EV_RST_DONE 0
`define FSC_EV_AN_RESTART 1
`define FSC_EV_COL_TEST 2

// AXI responses
`define FSC_RESP_OKAY 2'h0
`define FSC_RESP_SLVERR 2'h2

// Timing: fiber soft reset duration and strap settle time
`define FSC_CLK_PERIOD_NS 50
`define FSC_FIBER_RST_NS 1000
`define FSC_FIBER_RST_CYC ((`FSC_FIBER_RST_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_RST_CNT_W 5
`define FSC_STRAP_SETTLE 3'h4

`endif

// File: dv/fsc_control_regs_assertions.sv
// Port-level checker for the fiber and SGMII control register block
`timescale 1ns/1ps
module fsc_control_regs_chk (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst,
	// Inputs that cause outputs
	input wire i_sfd_enable,
	input wire i_receive_delimiter_pulse,
	input wire i_mode_sgmii_to_rgmii_bridge,
	input wire i_mode_mii_fx,
	input wire i_tx_en,
	// Watched outputs
	input wire o_mux_pin,
	input wire o_mac_isolate,
	input wire o_forced_duplex_valid,
	input wire o_sgmii_forced_speed_valid,
	input wire o_autoneg_enable,
	input wire o_collision_test,
	input wire o_sgmii_power_down,
	input wire o_fiber_reset,
	input wire o_autoneg_restart,
	input wire o_s_axi_bvalid,
	input wire o_s_axi_awready,
	input wire o_s_axi_wready,
	input wire o_s_axi_rvalid,
	input wire o_s_axi_arready,
	input wire o_irq
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	// ========================================
	// Pin, mode and control outputs
	mux_override_a: assert property (i_sfd_enable |=> o_mux_pin == $past(i_receive_delimiter_pulse))
		else $error("pin not forced to receive delimiter");
	isolate_mode_a: assert property (i_mode_sgmii_to_rgmii_bridge |-> !o_mac_isolate)
		else $error("isolate active in bridge mode");
	duplex_mode_a: assert property (o_forced_duplex_valid == i_mode_mii_fx)
		else $error("forced duplex outside its mode");
	speed_valid_a: assert property (o_sgmii_forced_speed_valid != o_autoneg_enable)
		else $error("forced speed used with autoneg on");
	col_cause_a: assert property (o_collision_test |-> $past(i_tx_en))
		else $error("collision without transmit enable");
	pwrdn_reset_a: assert property (o_sgmii_power_down |-> o_fiber_reset)
		else $error("power down without logic reset");
	// A soft reset must last a while, then end on its own
	rst_hold_a: assert property ($rose(o_fiber_reset) && !o_sgmii_power_down |=> o_fiber_reset [*8])
		else $error("fiber reset too short");
	rst_clear_a: assert property ($rose(o_fiber_reset) |-> ##[1:40] (!o_fiber_reset || o_sgmii_power_down))
		else $error("fiber reset never cleared");
	restart_pulse_a: assert property (o_autoneg_restart |=> !o_autoneg_restart)
		else $error("autoneg restart not a pulse");

	// ========================================
	// Register bus
	bvalid_busy_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while response pending");
	rvalid_busy_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken while data pending");

	// Main scenarios
	cover property ($rose(o_fiber_reset) && !o_sgmii_power_down);
	cover property (o_autoneg_restart);
	cover property (o_collision_test);
	cover property ($rose(o_irq));
endmodule

bind fsc_control_regs fsc_control_regs_chk u_chk (.*);

// File: dv/tb_fiber_sgmii_control_regs.sv
// Testbench for the fiber and SGMII control register block
`timescale 1ns/1ps
`include "fsc_defs.vh"
module tb_fiber_sgmii_control_regs;
	// ========================================
	// Design inputs and outputs
	logic i_ref_clk = 0, i_rst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
	logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, i_strap_aneg = 1, i_mode_mii_fx = 0;
	logic i_mode_sgmii_to_rgmii_bridge = 0;
	logic i_sfd_enable = 0, i_tx_en = 0, i_clk_out_src = 0, i_int_src = 0, i_link_status = 0;
	logic i_tx_sfd_pulse = 0, i_receive_delimiter_pulse = 0, i_wol_ind = 0, i_energy_detect = 0, i_pseudo_random_pattern_error = 0;
	logic i_led_two = 0, i_led_general_output = 0, i_mii_crs = 0, i_mii_col = 0;
	logic [11:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
	logic [2:0] i_s_axi_awprot = 0, i_s_axi_arprot = 0;
	logic [31:0] i_s_axi_wdata = 0;
	logic [3:0] i_s_axi_wstrb = 4'hF;
	logic [1:0] i_strap_speed = 2'h2;
	wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_mux_pin;
	wire o_fiber_reset, o_mac_loopback, o_sgmii_forced_speed_valid, o_autoneg_enable, o_autoneg_restart;
	wire o_sgmii_power_down, o_mac_isolate, o_forced_duplex_valid, o_forced_duplex_full;
	wire o_collision_test, o_link_loss_enable, o_irq;
	wire [1:0] o_s_axi_bresp, o_s_axi_rresp, o_speed_code;
	wire [31:0] o_s_axi_rdata;
	int n_mismatch = 0, check_count = 0, n_pulse = 0, n, m, c, k;

	fsc_control_regs uut (.*);

	initial forever #25 i_ref_clk = ~i_ref_clk;
	// Count restart pulses, since one may pass while a write is still finishing
	always @(posedge i_ref_clk) if (o_autoneg_restart === 1'b1) n_pulse <= n_pulse + 1;

	// ========================================
	// Report, compare and bus tasks
	task close_out;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %0h exp %0h", $time, g, e);
		end
	endtask
	// Waits on negedge see what the next rising edge samples
	task wr(input [11:0] a, input [15:0] d, input [1:0] er);
		logic ta, tw, tb, dn;
		dn = 0;
		@(posedge i_ref_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= {16'h0000, d};
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !dn; n++) begin
			@(negedge i_ref_clk);
			ta = i_s_axi_awvalid & o_s_axi_awready;
			tw = i_s_axi_wvalid & o_s_axi_wready;
			tb = o_s_axi_bvalid === 1'b1;
			if (tb) chk(o_s_axi_bresp, er);
			@(posedge i_ref_clk);
			if (ta) i_s_axi_awvalid <= 1'b0;
			if (tw) i_s_axi_wvalid <= 1'b0;
			if (tb) begin
				i_s_axi_bready <= 1'b0;
				dn = 1;
			end
		end
		if (!dn) begin
			n_mismatch++;
			close_out;
		end
	endtask
	task rd(input [11:0] a, input [31:0] e, input [1:0] er);
		logic ta, dn;
		dn = 0;
		@(posedge i_ref_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !dn; n++) begin
			@(negedge i_ref_clk);
			ta = i_s_axi_arvalid & o_s_axi_arready;
			dn = o_s_axi_rvalid === 1'b1;
			if (dn) chk(o_s_axi_rdata, e);
			if (dn) chk(o_s_axi_rresp, er);
			@(posedge i_ref_clk);
			if (ta) i_s_axi_arvalid <= 1'b0;
			if (dn) i_s_axi_rready <= 1'b0;
		end
		if (!dn) begin
			n_mismatch++;
			close_out;
		end
	endtask
	task stp(input int t);
		repeat (t) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask
	task src(input [11:0] s);
		@(posedge i_ref_clk);
		{i_mii_col, i_mii_crs, i_led_general_output, i_led_two, i_pseudo_random_pattern_error, i_energy_detect,
			i_wol_ind, i_receive_delimiter_pulse, i_tx_sfd_pulse, i_link_status, i_int_src, i_clk_out_src} <= s;
	endtask
	// Expected pin level for a select code; reserved codes give 0
	function logic pexp(input [3:0] cd, input [11:0] s);
		case (cd)
			4'h0: pexp = s[0];
			4'h2, 4'h3: pexp = s[cd - 1];
			4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: pexp = s[cd - 2];
			4'hF: pexp = 1'b1;
			default: pexp = 1'b0;
		endcase
	endfunction

	// ========================================
	// Main sequence
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		// Straps load a few cycles after release
		stp(8);
		rd(`FSC_OFF_PIN_MUX, `FSC_RST_PIN_MUX, `FSC_RESP_OKAY);
		rd(`FSC_OFF_LINK_LOSS, `FSC_RST_LINK_LOSS, `FSC_RESP_OKAY);
		rd(`FSC_OFF_CTRL, `FSC_RST_CTRL, `FSC_RESP_OKAY);
		chk(o_link_loss_enable, 0);
		chk(o_speed_code, 2'h2);
		chk(o_forced_duplex_full, 1);
		rd(12'h100, 0, `FSC_RESP_SLVERR);
		wr(12'h104, 16'hFFFF, `FSC_RESP_SLVERR);
		wr(`FSC_OFF_LINK_LOSS, 16'h1FFC, `FSC_RESP_OKAY);
		stp(1);
		chk(o_link_loss_enable, 1);
		wr(`FSC_OFF_LINK_LOSS, `FSC_RST_LINK_LOSS, `FSC_RESP_OKAY);
		stp(1);
		chk(o_link_loss_enable, 0);
		// Every select code against a walking source; upper bits kept at reset value
		for (c = 0; c < 16; c++) begin
			wr(`FSC_OFF_PIN_MUX, {12'h417, c[3:0]}, `FSC_RESP_OKAY);
			for (k = 0; k < 12; k++) begin
				src(12'h001 << k);
				stp(2);
				chk(o_mux_pin, pexp(c[3:0], 12'h001 << k));
			end
		end
		// Delimiter enable beats constant one
		@(posedge i_ref_clk);
		i_sfd_enable <= 1'b1;
		src(12'h010);
		stp(2);
		chk(o_mux_pin, 1);
		src(12'hFEF);
		stp(2);
		chk(o_mux_pin, 0);
		@(posedge i_ref_clk);
		i_sfd_enable <= 1'b0;
		wr(`FSC_OFF_CTRL, 16'h6400, `FSC_RESP_OKAY);
		stp(1);
		chk(o_mac_loopback, 1);
		chk(o_speed_code, 2'h1);
		chk(o_autoneg_enable, 0);
		chk(o_sgmii_forced_speed_valid, 1);
		chk(o_mac_isolate, 1);
		chk(o_forced_duplex_full, 0);
		rd(`FSC_OFF_CTRL, 32'h0000_6400, `FSC_RESP_OKAY);
		@(posedge i_ref_clk);
		i_mode_sgmii_to_rgmii_bridge <= 1'b1;
		i_mode_mii_fx <= 1'b1;
		stp(1);
		chk(o_mac_isolate, 0);
		chk(o_forced_duplex_valid, 1);
		@(posedge i_ref_clk);
		i_mode_sgmii_to_rgmii_bridge <= 1'b0;
		i_mode_mii_fx <= 1'b0;
		wr(`FSC_OFF_CTRL, 16'h0800, `FSC_RESP_OKAY);
		stp(1);
		chk(o_sgmii_power_down, 1);
		chk(o_fiber_reset, 1);
		// Collision test while its interrupt is masked
		wr(`FSC_OFF_CTRL, 16'h0080, `FSC_RESP_OKAY);
		@(posedge i_ref_clk);
		i_tx_en <= 1'b1;
		stp(2);
		chk(o_collision_test, 1);
		chk(o_irq, 0);
		@(posedge i_ref_clk);
		i_tx_en <= 1'b0;
		stp(2);
		chk(o_collision_test, 0);
		wr(`FSC_OFF_IRQ_MASK, 16'h0007, `FSC_RESP_OKAY);
		stp(1);
		chk(o_irq, 1);
		rd(`FSC_OFF_IRQ_STATUS, 32'h4, `FSC_RESP_OKAY);
		stp(1);
		chk(o_irq, 0);
		// Soft reset clears itself and raises its event
		wr(`FSC_OFF_CTRL, 16'h8000, `FSC_RESP_OKAY);
		rd(`FSC_OFF_CTRL, 32'h0000_8000, `FSC_RESP_OKAY);
		for (m = 0; m < 40 && o_fiber_reset === 1'b1; m++) @(negedge i_ref_clk);
		chk(o_fiber_reset, 0);
		// A reset that never ends is a hang: report at once
		if (m == 40) close_out;
		stp(1);
		chk(o_irq, 1);
		rd(`FSC_OFF_IRQ_STATUS, 32'h1, `FSC_RESP_OKAY);
		rd(`FSC_OFF_CTRL, 0, `FSC_RESP_OKAY);
		// Restart gives one pulse, none in the bridge mode
		m = n_pulse;
		wr(`FSC_OFF_CTRL, 16'h0200, `FSC_RESP_OKAY);
		stp(2);
		chk(n_pulse, m + 1);
		rd(`FSC_OFF_CTRL, 0, `FSC_RESP_OKAY);
		rd(`FSC_OFF_IRQ_STATUS, 32'h2, `FSC_RESP_OKAY);
		@(posedge i_ref_clk);
		i_mode_sgmii_to_rgmii_bridge <= 1'b1;
		wr(`FSC_OFF_CTRL, 16'h0200, `FSC_RESP_OKAY);
		stp(2);
		chk(n_pulse, m + 1);
		close_out;
	end

	// Cuts a hang short
	initial begin
		repeat (100000) @(posedge i_ref_clk);
		n_mismatch++;
		close_out;
	end
endmodule
